// ### design/tlic_prio_enc.sv
// fixed order priority encoder: lowest index wins
`timescale 1ns/10ps
module tlic_prio_enc (
   // request vector in, winner out
   tlic_arb_if.enc arb
);

   // scan from the top so the lowest set index is the last one kept
   always_comb begin
      arb.found = 1'b0;
      arb.idx   = '0;
      for (int i = tlic_pkg::NSRC - 1; i >= 0; i--) begin
         if (arb.req[i]) begin
            arb.found = 1'b1;
            arb.idx   = i[tlic_pkg::IDX_W-1:0];
         end
      end
   end

endmodule

// ### design/tlic_top.sv
// two level interrupt controller with apb registers and core handshake
//
// Function
// - source event sets its pending flag
// - flag sets even while source disabled
// - enabled flag requests call at instruction end
// - return resumes the interrupted program
// - per source enable bit in three registers
// - source enables honoured only with global enable
// - global enable low blocks every source
// - stale request taken before single cycle instruction
// - stale request dropped before multi cycle instruction
// - some flags self clear on vector
// - flag still set after return re-requests
// - software set of flag acts like event
// - seventeen sources with own vector and order
// - per source priority bit, low after reset
// - high preempts low, high never preempted
// - higher level wins simultaneous requests
// - fixed order breaks ties within level
// - decode every clock, one detect cycle
// - equal level waits return plus one instruction
`timescale 1ns/10ps
module tlic_top (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // interrupt sources
   input  wire logic [16:0] src_event,
   // processor core
   input  wire logic        instr_done,
   input  wire logic        irq_ack,
   input  wire logic        return_done,
   output logic             irq_req,
   output logic      [15:0] irq_vector,
   output logic             irq_level,
   output logic             irq_active_lo,
   output logic             irq_active_hi
);

   // ==========================================================
   // state
   logic [7:0]  en0_reg;
   logic [7:0]  en1_reg;
   logic [1:0]  en2_reg;
   logic [6:0]  pri0_reg;
   logic [7:0]  pri1_reg;
   logic [1:0]  pri2_reg;
   logic [16:0] pend_reg;
   logic [16:0] pend_next;
   logic        samp_valid_reg;
   logic [4:0]  samp_idx_reg;
   logic        samp_lvl_reg;
   logic        req_reg;
   logic [4:0]  req_idx_reg;
   logic [15:0] vec_reg;
   logic        lvl_reg;
   logic        act_lo_reg;
   logic        act_hi_reg;
   logic        hold_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;

   // ==========================================================
   // apb decode
   wire         apb_setup = psel & ~penable;
   wire         apb_wr    = psel & penable & pready_reg & pwrite;
   wire         aligned   = (paddr[1:0] == 2'b00);
   wire         sel_en0   = aligned & (paddr == tlic_pkg::OFS_EN0);
   wire         sel_en1   = aligned & (paddr == tlic_pkg::OFS_EN1);
   wire         sel_en2   = aligned & (paddr == tlic_pkg::OFS_EN2);
   wire         sel_pri0  = aligned & (paddr == tlic_pkg::OFS_PRI0);
   wire         sel_pri1  = aligned & (paddr == tlic_pkg::OFS_PRI1);
   wire         sel_pri2  = aligned & (paddr == tlic_pkg::OFS_PRI2);
   wire         sel_pend  = aligned & (paddr == tlic_pkg::OFS_PEND);
   wire         sel_pclr  = aligned & (paddr == tlic_pkg::OFS_PEND_CLR);
   wire         sel_stat  = aligned & (paddr == tlic_pkg::OFS_STATUS);
   wire         addr_ok   = sel_en0 | sel_en1 | sel_en2 | sel_pri0 | sel_pri1
                          | sel_pri2 | sel_pend | sel_pclr | sel_stat;

   // read mux; narrow registers sit low, upper bits zero
   wire [31:0]  rd_data =
        sel_en0  ? {24'h000000, en0_reg}
      : sel_en1  ? {24'h000000, en1_reg}
      : sel_en2  ? {30'h00000000, en2_reg}
      : sel_pri0 ? {25'h0000000, pri0_reg}
      : sel_pri1 ? {24'h000000, pri1_reg}
      : sel_pri2 ? {30'h00000000, pri2_reg}
      : sel_pend ? {15'h0000, pend_reg}
      : sel_stat ? {22'h000000, req_reg, hold_reg, lvl_reg, act_hi_reg,
                    act_lo_reg, req_idx_reg}
      : 32'h00000000;

   // ==========================================================
   // apb answer: one wait-free access phase, error on unmapped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg  <= 32'h00000000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= apb_setup;
         pslverr_reg <= apb_setup & ~addr_ok;
         if (apb_setup) begin
            prdata_reg <= rd_data;
         end
      end
   end

   // ==========================================================
   // enable and priority registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en0_reg  <= tlic_pkg::EN_RST;
         en1_reg  <= tlic_pkg::EN_RST;
         en2_reg  <= tlic_pkg::EN_RST[1:0];
         pri0_reg <= tlic_pkg::PRI_RST[6:0];
         pri1_reg <= tlic_pkg::PRI_RST;
         pri2_reg <= tlic_pkg::PRI_RST[1:0];
      end else if (apb_wr) begin
         if (sel_en0)  en0_reg  <= pwdata[7:0];
         if (sel_en1)  en1_reg  <= pwdata[7:0];
         if (sel_en2)  en2_reg  <= pwdata[1:0];
         if (sel_pri0) pri0_reg <= pwdata[6:0];
         if (sel_pri1) pri1_reg <= pwdata[7:0];
         if (sel_pri2) pri2_reg <= pwdata[1:0];
      end
   end

   // ==========================================================
   // pending flags
   wire         global_irq_enable = en0_reg[tlic_pkg::GLOBAL_EN_BIT];
   wire [16:0]  en_vec    = {en2_reg, en1_reg, en0_reg[tlic_pkg::EN0_SRC_W-1:0]};
   wire [16:0]  pri_vec   = {pri2_reg, pri1_reg, pri0_reg};
   wire [16:0]  ack_onehot = 17'(17'h00001 << req_idx_reg);
   // sets win over both clears so no event is lost
   wire [16:0]  set_mask  = src_event
                          | ({17{apb_wr & sel_pend}} & pwdata[16:0]);
   wire [16:0]  clr_mask  = ({17{apb_wr & sel_pclr}} & pwdata[16:0])
                          | ({17{req_reg & irq_ack}} & ack_onehot
                             & tlic_pkg::HW_CLEAR_MASK);

   assign pend_next = (pend_reg & ~clr_mask) | set_mask;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= tlic_pkg::PEND_RST;
      end else begin
         pend_reg <= pend_next;
      end
   end

   // ==========================================================
   // arbitration: high level beats low, fixed order within level
   tlic_arb_if hi_arb ();
   tlic_arb_if lo_arb ();

   wire [16:0]  eligible  = pend_reg & en_vec & {17{global_irq_enable}};
   // a running high handler blocks all; a running low one blocks low
   assign hi_arb.req = eligible & pri_vec & {17{~act_hi_reg}};
   assign lo_arb.req = eligible & ~pri_vec
                     & {17{~act_hi_reg & ~act_lo_reg}};

   tlic_prio_enc u_hi_enc (
      .arb (hi_arb.enc)
   );

   tlic_prio_enc u_lo_enc (
      .arb (lo_arb.enc)
   );

   wire         cand_valid = hi_arb.found | lo_arb.found;
   wire [4:0]   cand_idx   = hi_arb.found ? hi_arb.idx : lo_arb.idx;

   // ==========================================================
   // one detect cycle; the sample is one clock old when the boundary
   // comes, so a request seen just before an enable clear survives a
   // single cycle instruction but is re-decoded during a longer one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_valid_reg <= 1'b0;
         samp_idx_reg   <= '0;
         samp_lvl_reg   <= 1'b0;
      end else begin
         samp_valid_reg <= cand_valid;
         samp_idx_reg   <= cand_idx;
         samp_lvl_reg   <= hi_arb.found;
      end
   end

   // ==========================================================
   // request to the core, raised only at an instruction boundary
   wire         take = instr_done & samp_valid_reg & ~hold_reg
                     & ~req_reg & ~return_done;
   wire [15:0]  take_vec = 16'(tlic_pkg::VEC_BASE
                              + 16'(samp_idx_reg) * tlic_pkg::VEC_STEP);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_reg     <= 1'b0;
         req_idx_reg <= '0;
         vec_reg     <= 16'h0000;
         lvl_reg     <= 1'b0;
      end else if (take) begin
         req_reg     <= 1'b1;
         req_idx_reg <= samp_idx_reg;
         vec_reg     <= take_vec;
         lvl_reg     <= samp_lvl_reg;
      end else if (irq_ack) begin
         req_reg     <= 1'b0;
      end
   end

   // ==========================================================
   // active levels; return closes the highest one open
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_lo_reg <= 1'b0;
         act_hi_reg <= 1'b0;
      end else if (req_reg & irq_ack) begin
         if (lvl_reg) act_hi_reg <= 1'b1;
         else         act_lo_reg <= 1'b1;
      end else if (return_done) begin
         if (act_hi_reg) act_hi_reg <= 1'b0;
         else            act_lo_reg <= 1'b0;
      end
   end

   // ==========================================================
   // after a return one more instruction runs before any new call
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_reg <= 1'b0;
      end else if (return_done) begin
         hold_reg <= 1'b1;
      end else if (instr_done) begin
         hold_reg <= 1'b0;
      end
   end

   // ==========================================================
   // outputs, all from flops
   assign prdata        = prdata_reg;
   assign pready        = pready_reg;
   assign pslverr       = pslverr_reg;
   assign irq_req       = req_reg;
   assign irq_vector    = vec_reg;
   assign irq_level     = lvl_reg;
   assign irq_active_lo = act_lo_reg;
   assign irq_active_hi = act_hi_reg;

   // ==========================================================
   // assertions
   sequence s_return_wait;
      return_done ##1 !instr_done;
   endsequence

   sequence s_apb_setup;
      psel && !penable;
   endsequence

   a_global_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(req_reg) |-> $past(global_irq_enable, 2))
      else $error("request raised with global enable low");

   a_source_enable: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(req_reg) |-> ($past(en_vec, 2) & (17'h00001 << req_idx_reg)) != 17'h00000)
      else $error("request raised for a disabled source");

   a_at_boundary: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(req_reg) |-> $past(instr_done) && !$past(return_done))
      else $error("request raised off an instruction boundary");

   a_high_no_preempt: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(req_reg) |-> !$past(act_hi_reg) && ($past(act_lo_reg) -> lvl_reg))
      else $error("running handler preempted wrongly");

   a_return_hold: assert property (@(posedge pclk) disable iff (!presetn)
      s_return_wait |-> !$rose(req_reg))
      else $error("request raised before instruction after return");

   a_return_reenter: assert property (@(posedge pclk) disable iff (!presetn)
      return_done || (hold_reg && !instr_done) |=> hold_reg)
      else $error("hold after return not kept until next instruction");

   a_event_sets: assert property (@(posedge pclk) disable iff (!presetn)
      (src_event != 17'h0) |=> (pend_reg & $past(src_event)) == $past(src_event))
      else $error("source event did not set its pending flag");

   a_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
      apb_wr && sel_pend |=> (pend_reg & $past(pwdata[16:0])) == $past(pwdata[16:0]))
      else $error("software set of pending flag lost");

   a_auto_clear: assert property (@(posedge pclk) disable iff (!presetn)
      req_reg && irq_ack && !src_event[req_idx_reg] && !(apb_wr && (sel_pend || sel_pclr))
      |=> pend_reg[$past(req_idx_reg)] == !$past(tlic_pkg::HW_CLEAR_MASK[req_idx_reg])
          || !$past(pend_reg[req_idx_reg]))
      else $error("pending flag auto clear wrong");

   a_vector_tie: assert property (@(posedge pclk) disable iff (!presetn)
      req_reg |-> vec_reg == 16'(tlic_pkg::VEC_BASE
                                 + 16'(req_idx_reg) * tlic_pkg::VEC_STEP))
      else $error("vector does not match source");

   a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      s_apb_setup |=> pready_reg && (pslverr_reg == !$past(addr_ok)))
      else $error("apb answer not given in access phase");

endmodule

// ### pkg/tlic_arb_if.sv
// request vector and winner between the controller and a priority encoder
`timescale 1ns/10ps
interface tlic_arb_if;
   logic [16:0] req;
   logic        found;
   logic [4:0]  idx;

   modport enc  (input req, output found, idx);
   modport user (output req, input found, idx);
endinterface

// ### pkg/tlic_pkg.sv
// constants, offsets and field layout of the two level interrupt controller
package tlic_pkg;

   // ==========================================================
   // sources and vectors
   localparam int          NSRC         = 17;
   localparam int          IDX_W        = 5;
   localparam logic [15:0] VEC_BASE     = 16'h0003;
   localparam logic [15:0] VEC_STEP     = 16'h0008;
   // sources whose pending flag clears itself when the core vectors
   localparam logic [16:0] HW_CLEAR_MASK = 17'h0000f;

   // ==========================================================
   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_EN0      = 8'h00;
   localparam logic [7:0] OFS_EN1      = 8'h04;
   localparam logic [7:0] OFS_EN2      = 8'h08;
   localparam logic [7:0] OFS_PRI0     = 8'h0c;
   localparam logic [7:0] OFS_PRI1     = 8'h10;
   localparam logic [7:0] OFS_PRI2     = 8'h14;
   localparam logic [7:0] OFS_PEND     = 8'h18;
   localparam logic [7:0] OFS_PEND_CLR = 8'h1c;
   localparam logic [7:0] OFS_STATUS   = 8'h20;

   // ==========================================================
   // field layout
   localparam int GLOBAL_EN_BIT = 7;
   localparam int EN0_SRC_W     = 7;
   localparam int EN2_SRC_W     = 2;

   // ==========================================================
   // reset values
   localparam logic [7:0]  EN_RST   = 8'h00;
   localparam logic [7:0]  PRI_RST  = 8'h00;
   localparam logic [16:0] PEND_RST = 17'h00000;

endpackage

// ### testbench/tlic_core_model.sv
// behavioural processor core: instruction boundaries, call acknowledge, returns
`timescale 1ns/10ps
module tlic_core_model (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // controller side
   input  wire logic irq_req,
   output logic      instr_done,
   output logic      irq_ack,
   output logic      return_done,
   // bench commands
   input  wire logic ret_go,
   input  wire logic ack_slow
);
   logic [1:0] phase_reg;
   logic [2:0] call_reg;
   logic [1:0] wait_reg;
   logic       ret_reg;

   // ==========================================================
   // core sequencing
   // one instruction every four cycles; none during the long call
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg  <= 2'h0;
         call_reg   <= 3'h0;
         wait_reg   <= 2'h0;
         ret_reg    <= 1'b0;
         instr_done <= 1'b0;
         irq_ack    <= 1'b0;
         return_done <= 1'b0;
      end else begin
         instr_done <= 1'b0;
         irq_ack    <= 1'b0;
         return_done <= 1'b0;
         if (call_reg != 3'h0) begin
            call_reg <= call_reg - 3'h1; // long call in flight
         end else if (irq_req && !irq_ack) begin
            // slow mode keeps the request standing a few cycles
            if (wait_reg == 2'h0) begin
               irq_ack  <= 1'b1;
               call_reg <= 3'h4;
               wait_reg <= ack_slow ? 2'h3 : 2'h0;
            end else begin
               wait_reg <= wait_reg - 2'h1;
            end
         end else begin
            phase_reg  <= phase_reg + 2'h1;
            instr_done <= (phase_reg == 2'h3);
            // return lands away from a boundary so the two never coincide
            if (ret_reg && phase_reg == 2'h1) begin
               return_done <= 1'b1;
               ret_reg   <= 1'b0;
            end
         end
         if (ret_go) begin
            ret_reg <= 1'b1;
         end
      end
   end
endmodule

// ### testbench/tlic_tb_top.sv
// self-checking bench of the two level interrupt controller
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tlic_tb_top;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, irq_req, irq_level, irq_active_lo, irq_active_hi;
   logic [15:0] irq_vector;
   logic [16:0] src_event = 17'h0, p, pri;
   logic        instr_done, irq_ack, return_done, ret_go = 1'b0, ack_slow = 1'b0;
   int          seed = 78816, err_total = 0, n_checks = 0, i, a, b;
   logic [31:0] v;
   logic [31:0] msk [6] = '{32'hff, 32'hff, 32'h03, 32'h7f, 32'hff, 32'h03};

   // ==========================================================
   // clock, design and core
   always #4 pclk = ~pclk;
   tlic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_event(src_event), .instr_done(instr_done), .irq_ack(irq_ack),
      .return_done(return_done), .irq_req(irq_req), .irq_vector(irq_vector),
      .irq_level(irq_level), .irq_active_lo(irq_active_lo), .irq_active_hi(irq_active_hi));
   tlic_core_model core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
      .instr_done(instr_done), .irq_ack(irq_ack), .return_done(return_done),
      .ret_go(ret_go), .ack_slow(ack_slow));

   // ==========================================================
   // verdict
   task results;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // apb master; holds the request until pready is seen at an edge
   task apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (k == 50) begin err_total++; results(); end
   endtask

   task wr(input logic [7:0] ad, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, ad, d, r, e);
   endtask

   task rdc(input logic [7:0] ad, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, ad, 32'h0, r, e);
      `CHK(r, x)
      `CHK(e, xe)
   endtask

   // bounded wait: 0 request, 1 return done, 2 instruction boundary
   task wait_on(input int which, input logic lv);
      int k;
      for (k = 0; k < 300; k++) begin
         @(posedge pclk);
         if ((which == 0 ? irq_req : which == 1 ? return_done : instr_done) === lv) break;
      end
      if (k == 300) begin err_total++; results(); end
   endtask

   task ret;
      @(posedge pclk) ret_go <= 1'b1;
      @(posedge pclk) ret_go <= 1'b0;
      wait_on(1, 1'b1);
   endtask

   task quiet(input int n);
      repeat (n) begin @(posedge pclk); `CHK(irq_req, 1'b0) end
   endtask

   // expected handler address: high level first, then lowest index
   function automatic logic [15:0] exp_vec(input logic [16:0] pd, input logic [16:0] pr);
      logic [16:0] s;
      int          j;
      exp_vec = 16'h0000;
      s = (|(pd & pr)) ? (pd & pr) : pd;
      for (j = 16; j >= 0; j--) begin
         if (s[j]) exp_vec = tlic_pkg::VEC_BASE + tlic_pkg::VEC_STEP * 16'(j);
      end
   endfunction

   // ==========================================================
   // main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then an unmapped and an unaligned place
      for (i = 0; i <= 32; i += 4) rdc(8'(i), 32'h0, 1'b0);
      rdc(8'h24, 32'h0, 1'b1);
      rdc(8'h02, 32'h0, 1'b1);
      // enable and priority bits read back within their widths
      for (i = 0; i < 6; i++) begin
         v = $random(seed) & msk[i];
         wr(8'(4 * i), v);
         rdc(8'(4 * i), v, 1'b0);
         wr(8'(4 * i), 32'h0);
      end
      // flag sets while blocked by the global enable
      wr(tlic_pkg::OFS_EN0, 32'h7f); wr(tlic_pkg::OFS_EN1, 32'hff); wr(tlic_pkg::OFS_EN2, 32'h3);
      @(posedge pclk) src_event <= 17'h00020;
      @(posedge pclk) src_event <= 17'h0;
      rdc(tlic_pkg::OFS_PEND, 32'h20, 1'b0);
      quiet(20);
      wr(tlic_pkg::OFS_EN0, 32'hff);
      wait_on(0, 1'b1);
      `CHK(irq_vector, exp_vec(17'h20, 17'h0))
      wait_on(0, 1'b0);
      rdc(tlic_pkg::OFS_PEND, 32'h20, 1'b0);
      // flag left set: first boundary after return consumed, next one requests
      ret();
      wait_on(2, 1'b1);
      #1 `CHK(irq_req, 1'b0)
      wait_on(2, 1'b1);
      #1 `CHK(irq_req, 1'b1)
      wr(tlic_pkg::OFS_PEND_CLR, 32'h1ffff);
      wait_on(0, 1'b0);
      ret();
      // self-clearing source
      @(posedge pclk) src_event <= 17'h00008;
      @(posedge pclk) src_event <= 17'h0;
      wait_on(0, 1'b1);
      `CHK(irq_vector, 16'h001b)
      wait_on(0, 1'b0);
      #1 `CHK(irq_active_lo, 1'b1)
      rdc(tlic_pkg::OFS_PEND, 32'h0, 1'b0);
      ret();
      // random simultaneous pairs set by software
      for (i = 0; i < 12; i++) begin
         a = $unsigned($random(seed)) % 17;
         b = ($unsigned($random(seed)) % 16 + a + 1) % 17;
         pri = 17'($random(seed));
         ack_slow <= 1'($random(seed));
         wr(tlic_pkg::OFS_PRI0, {25'h0, pri[6:0]});
         wr(tlic_pkg::OFS_PRI1, {24'h0, pri[14:7]});
         wr(tlic_pkg::OFS_PRI2, {30'h0, pri[16:15]});
         p = (17'h1 << a) | (17'h1 << b);
         wr(tlic_pkg::OFS_PEND, {15'h0, p});
         wait_on(0, 1'b1);
         `CHK(irq_vector, exp_vec(p, pri))
         `CHK(irq_level, |(p & pri))
         wr(tlic_pkg::OFS_PEND_CLR, 32'h1ffff);
         wait_on(0, 1'b0);
         ret();
      end
      // nesting: sources 9 and 10 high, the rest low
      wr(tlic_pkg::OFS_PRI0, 32'h0); wr(tlic_pkg::OFS_PRI1, 32'h0c); wr(tlic_pkg::OFS_PRI2, 32'h0);
      wr(tlic_pkg::OFS_PEND, 32'h100);
      wait_on(0, 1'b1);
      wr(tlic_pkg::OFS_PEND_CLR, 32'h1ffff);
      wait_on(0, 1'b0);
      wr(tlic_pkg::OFS_PEND, 32'h1000);
      quiet(20);
      wr(tlic_pkg::OFS_PEND, 32'h200);
      wait_on(0, 1'b1);
      `CHK(irq_vector, exp_vec(17'h200, 17'h0))
      `CHK(irq_level, 1'b1)
      wr(tlic_pkg::OFS_PEND_CLR, 32'h1ffff);
      wait_on(0, 1'b0);
      #1 `CHK(irq_active_hi, 1'b1)
      wr(tlic_pkg::OFS_PEND, 32'h400);
      quiet(20);
      wr(tlic_pkg::OFS_PEND_CLR, 32'h1ffff);
      ret();
      #1 `CHK({irq_active_hi, irq_active_lo}, 2'b01)
      ret();
      #1 `CHK(irq_active_lo, 1'b0)
      // global enable cleared, the clear padded by a second one
      wr(tlic_pkg::OFS_EN0, 32'h7f);
      wr(tlic_pkg::OFS_EN0, 32'h7f);
      wr(tlic_pkg::OFS_PEND, 32'h1);
      quiet(20);
      results();
   end
endmodule
